// file: hdl/sbs_pkg.sv
// shared constants, types and burst decode for the burst sram control block
package sbs_pkg;

    localparam int SBS_ADDR_W     = 17;
    localparam int SBS_LANES      = 4;
    localparam int SBS_LANE_W     = 9;
    localparam int SBS_DATA_W     = SBS_LANES * SBS_LANE_W;
    localparam int SBS_FIFO_DEPTH = 16;
    localparam int SBS_BURST_W    = 2;

    localparam logic [SBS_BURST_W-1:0] SBS_CNT_RESET = 2'h0;
    localparam logic [SBS_BURST_W-1:0] SBS_CNT_STEP  = 2'h1;
    localparam logic [SBS_LANES-1:0]   SBS_ALL_LANES = 4'hF;
    localparam logic [SBS_LANES-1:0]   SBS_NO_LANES  = 4'h0;

    typedef enum logic [1:0] {
        SBS_IDLE  = 2'b00,
        SBS_READ  = 2'b01,
        SBS_WRITE = 2'b10
    } sbs_state_e;

    // one posted write: word address, lane mask and data
    typedef struct packed {
        logic [SBS_ADDR_W-1:0] addr;
        logic [SBS_LANES-1:0]  mask;
        logic [SBS_DATA_W-1:0] data;
    } sbs_wr_s;

    localparam int SBS_WR_W = $bits(sbs_wr_s);

    // low two address bits of a burst: interleaved xor, linear add modulo four
    function automatic logic [SBS_BURST_W-1:0] sbs_burst_lo(
        input logic [SBS_BURST_W-1:0] start,
        input logic [SBS_BURST_W-1:0] count,
        input logic                   interleave
    );
        sbs_burst_lo = interleave ? (start ^ count) : (start + count);
    endfunction

endpackage

// file: hdl/sbs_sram_ctrl.sv
// burst sram control front end with posted-write fifo and lane memories
//
// Contract
// - Address inputs are captured into registers at the clock rising edge.
// - During burst and wait cycles the low two address bits come from the counter.
// - A byte select low requests a write of its byte, only while gate low.
// - Each byte select governs exactly its own lane; narrow variant has lanes a, b.
// - Data drivers are off in the cycle after a write is registered, and while output enable is high.
// - Byte selects act only when the active-low gate is sampled low.
// - Full word write low writes every lane regardless of gate and selects.
// - Addresses, data, enables and controls register only on the rising edge.
// - Active-low chip enable selects the device and qualifies the processor strobe.
// - Active-low depth enable must be low for the device to be selected.
// - Active-high depth enable must be high for the device to be selected.
// - Output enable is active low, unclocked, and gates drivers asynchronously.
// - Burst step low advances the counter; high holds it for a wait cycle.
// - Processor strobe with chip enable low deselects or loads the address and starts a read.
// - Controller strobe deselects or loads address and starts read or write.
// - Burst order input low gives linear order, high gives interleaved order.
// - Burst counter is two bits; four words share the loaded upper address.
// - A processor-strobe cycle is always a read; writes follow in wait cycles.
`timescale 1ns/1ps

module sbs_fifo #(
    parameter int W     = sbs_pkg::SBS_WR_W,
    parameter int DEPTH = sbs_pkg::SBS_FIFO_DEPTH
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    import sbs_pkg::*;

    localparam int PW = $clog2(DEPTH);

    logic [W-1:0]  slot [0:DEPTH-1];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0]   count_q;
    logic          push;
    logic          pop;

    assign in_ready  = (count_q != (PW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = slot[rd_ptr_q];

    always_ff @(posedge clock) begin
        if (push) begin
            slot[wr_ptr_q] <= in_data;
        end
    end

    // pointers wrap only for power-of-two depths
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_q + PW'(push);
            rd_ptr_q <= rd_ptr_q + PW'(pop);
            count_q  <= count_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

module sbs_sram_ctrl #(
    parameter int LANES      = sbs_pkg::SBS_LANES,
    parameter int FIFO_DEPTH = sbs_pkg::SBS_FIFO_DEPTH
) (
    input  wire logic                            clock,
    input  wire logic                            reset_n,
    input  wire logic [sbs_pkg::SBS_ADDR_W-3:0]  addr_upper,
    input  wire logic                            addr_bit_one,
    input  wire logic                            addr_bit_zero,
    input  wire logic                            chip_enable_n,
    input  wire logic                            depth_bank_enable_n,
    input  wire logic                            depth_expansion_select,
    input  wire logic                            processor_addr_strobe_n,
    input  wire logic                            controller_addr_strobe_n,
    input  wire logic                            burst_step_n,
    input  wire logic                            burst_mode_interleave,
    input  wire logic                            byte_write_gate_n,
    input  wire logic                            full_word_write_n,
    input  wire logic                            byte_sel_lane_a_n,
    input  wire logic                            byte_sel_lane_b_n,
    input  wire logic                            byte_sel_lane_c_n,
    input  wire logic                            byte_sel_lane_d_n,
    input  wire logic                            output_enable_n,
    input  wire logic [sbs_pkg::SBS_LANE_W-1:0]  data_lane_a_in,
    input  wire logic [sbs_pkg::SBS_LANE_W-1:0]  data_lane_b_in,
    input  wire logic [sbs_pkg::SBS_LANE_W-1:0]  data_lane_c_in,
    input  wire logic [sbs_pkg::SBS_LANE_W-1:0]  data_lane_d_in,
    output logic [sbs_pkg::SBS_LANE_W-1:0]       data_lane_a_out,
    output logic [sbs_pkg::SBS_LANE_W-1:0]       data_lane_b_out,
    output logic [sbs_pkg::SBS_LANE_W-1:0]       data_lane_c_out,
    output logic [sbs_pkg::SBS_LANE_W-1:0]       data_lane_d_out,
    output logic                                 data_oe_n,
    output logic                                 write_buf_ready
);
    import sbs_pkg::*;

    localparam int LW = SBS_LANE_W;

    sbs_state_e                state_q;
    sbs_state_e                state_d;
    logic [SBS_ADDR_W-1:0]     base_q;
    logic [SBS_ADDR_W-1:0]     base_d;
    logic [SBS_BURST_W-1:0]    cnt_q;
    logic [SBS_BURST_W-1:0]    cnt_d;
    logic [SBS_ADDR_W-1:0]     ext_addr;
    logic [SBS_ADDR_W-1:0]     acc_addr;
    logic [SBS_LANES-1:0]      sel_n;
    logic [SBS_LANES-1:0]      lane_on;
    logic [SBS_LANES-1:0]      lane_mask;
    logic [SBS_DATA_W-1:0]     din;
    logic [SBS_DATA_W-1:0]     dout;
    logic                      sel_ok;
    logic                      padsp;
    logic                      start_p;
    logic                      desel_p;
    logic                      c_evt;
    logic                      start_c;
    logic                      desel_c;
    logic                      load;
    logic                      desel;
    logic                      cont;
    logic                      gate_wr;
    logic                      wr_req;
    logic                      rd_now;
    logic                      wr_now;
    logic                      drain_ready;
    logic                      drain_valid;
    sbs_wr_s                   wr_ent;
    sbs_wr_s                   drain_ent;

    // selection and strobe decode on the values present at the edge
    assign ext_addr = {addr_upper, addr_bit_one, addr_bit_zero};
    assign sel_ok   = ~chip_enable_n & ~depth_bank_enable_n & depth_expansion_select;
    assign padsp    = ~processor_addr_strobe_n & ~chip_enable_n;
    assign start_p  = padsp & sel_ok;
    assign desel_p  = padsp & ~sel_ok;
    assign c_evt    = ~controller_addr_strobe_n & ~padsp;
    assign start_c  = c_evt & sel_ok;
    assign desel_c  = c_evt & ~sel_ok;
    assign load     = start_p | start_c;
    assign desel    = desel_p | desel_c;
    assign cont     = (state_q != SBS_IDLE) & ~load & ~desel;

    // write qualification and lane mapping
    assign sel_n = {byte_sel_lane_d_n, byte_sel_lane_c_n, byte_sel_lane_b_n, byte_sel_lane_a_n};
    assign gate_wr   = ~byte_write_gate_n & (|(~sel_n & lane_on));
    assign lane_mask = ~full_word_write_n ? lane_on
                     : (~byte_write_gate_n ? (~sel_n & lane_on) : SBS_NO_LANES);
    assign wr_req    = ~full_word_write_n | gate_wr;

    // next state: processor-strobe starts ignore the write controls
    assign state_d = desel   ? SBS_IDLE
                   : start_p ? SBS_READ
                   : (start_c | cont) ? (wr_req ? SBS_WRITE : SBS_READ)
                   : state_q;
    assign rd_now  = (state_d == SBS_READ);
    assign wr_now  = (state_d == SBS_WRITE);

    // burst counter and access address
    assign base_d   = load ? ext_addr : base_q;
    assign cnt_d    = load ? SBS_CNT_RESET
                    : ((cont & ~burst_step_n) ? cnt_q + SBS_CNT_STEP : cnt_q);
    assign acc_addr = {base_d[SBS_ADDR_W-1:SBS_BURST_W],
                       sbs_burst_lo(base_d[SBS_BURST_W-1:0], cnt_d,
                                    burst_mode_interleave)};

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            state_q <= SBS_IDLE;
            base_q  <= '0;
            cnt_q   <= SBS_CNT_RESET;
        end else begin
            state_q <= state_d;
            base_q  <= base_d;
            cnt_q   <= cnt_d;
        end
    end

    // writes post into the fifo; the array drains it only when no read needs the port
    assign din         = {data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in};
    assign wr_ent      = '{addr: acc_addr, mask: lane_mask, data: din};
    assign drain_ready = ~rd_now;

    sbs_fifo #(
        .W     (SBS_WR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .clock     (clock),
        .reset_n   (reset_n),
        .in_valid  (wr_now),
        .in_ready  (write_buf_ready),
        .in_data   (wr_ent),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_ent)
    );

    // one memory per lane; lanes past LANES are absent and read as zero
    for (genvar i = 0; i < SBS_LANES; i++) begin : g_lane
        if (i < LANES) begin : g_on
            logic [LW-1:0] mem [0:(2**SBS_ADDR_W)-1];
            logic [LW-1:0] rd_q;
            assign lane_on[i] = 1'b1;
            always_ff @(posedge clock) begin
                if (drain_valid & drain_ready & drain_ent.mask[i]) begin
                    mem[drain_ent.addr] <= drain_ent.data[i*LW +: LW];
                end
            end
            always_ff @(posedge clock) begin
                if (!reset_n) begin
                    rd_q <= '0;
                end else if (rd_now) begin
                    rd_q <= mem[acc_addr];
                end
            end
            assign dout[i*LW +: LW] = rd_q;
        end else begin : g_off
            assign lane_on[i]       = 1'b0;
            assign dout[i*LW +: LW] = '0;
        end
    end

    assign data_lane_a_out = dout[0*LW +: LW];
    assign data_lane_b_out = dout[1*LW +: LW];
    assign data_lane_c_out = dout[2*LW +: LW];
    assign data_lane_d_out = dout[3*LW +: LW];

    // output enable is unclocked so the drivers follow it without waiting for an edge
    assign data_oe_n = ~((state_q == SBS_READ) & ~output_enable_n);

    // checks
    sequence s_load_p;
        start_p;
    endsequence

    sequence s_step;
        cont & ~burst_step_n;
    endsequence

    property p_proc_read;
        @(posedge clock) disable iff (!reset_n)
        s_load_p |=> (state_q == SBS_READ) && (base_q == $past(ext_addr)) && (cnt_q == 2'h0);
    endproperty
    a_proc_read: assert property (p_proc_read) else $error("processor start not a read");

    property p_proc_no_write;
        @(posedge clock) disable iff (!reset_n)
        (start_p && !full_word_write_n) |-> !wr_now;
    endproperty
    a_proc_no_write: assert property (p_proc_no_write) else $error("write on proc start");

    property p_gate;
        @(posedge clock) disable iff (!reset_n)
        (!processor_addr_strobe_n && chip_enable_n && controller_addr_strobe_n
         && state_q == SBS_IDLE) |=> (state_q == SBS_IDLE);
    endproperty
    a_gate: assert property (p_gate) else $error("strobe acted while disabled");

    property p_desel;
        @(posedge clock) disable iff (!reset_n)
        desel |=> (state_q == SBS_IDLE) && data_oe_n;
    endproperty
    a_desel: assert property (p_desel) else $error("deselect did not idle");

    property p_select;
        @(posedge clock) disable iff (!reset_n)
        (!controller_addr_strobe_n && processor_addr_strobe_n
         && (depth_bank_enable_n || !depth_expansion_select)) |=> (state_q == SBS_IDLE);
    endproperty
    a_select: assert property (p_select) else $error("selected with depth enable off");

    property p_two_steps;
        @(posedge clock) disable iff (!reset_n)
        s_load_p ##1 s_step ##1 s_step |=> (cnt_q == 2'h2);
    endproperty
    a_two_steps: assert property (p_two_steps) else $error("burst count wrong");

    property p_wait;
        @(posedge clock) disable iff (!reset_n)
        (cont && burst_step_n) |=> (cnt_q == $past(cnt_q)) && (base_q == $past(base_q));
    endproperty
    a_wait: assert property (p_wait) else $error("wait cycle moved address");

    property p_order;
        @(posedge clock) disable iff (!reset_n)
        (cont && !load) |-> acc_addr[1:0] == (burst_mode_interleave
            ? (base_q[1:0] ^ cnt_d) : 2'(base_q[1:0] + cnt_d));
    endproperty
    a_order: assert property (p_order) else $error("burst order wrong");

    property p_full_word;
        @(posedge clock) disable iff (!reset_n)
        (wr_now && !full_word_write_n) |-> (wr_ent.mask == lane_on);
    endproperty
    a_full_word: assert property (p_full_word) else $error("full word not all lanes");

    property p_no_gate;
        @(posedge clock) disable iff (!reset_n)
        (full_word_write_n && byte_write_gate_n && cont) |=> (state_q == SBS_READ);
    endproperty
    a_no_gate: assert property (p_no_gate) else $error("write without gate");

    property p_lane;
        @(posedge clock) disable iff (!reset_n)
        (wr_now && full_word_write_n) |-> (wr_ent.mask == (~sel_n & lane_on));
    endproperty
    a_lane: assert property (p_lane) else $error("lane mask mismatch");

    property p_oe;
        @(posedge clock) disable iff (!reset_n)
        (output_enable_n || state_q == SBS_WRITE) |-> data_oe_n;
    endproperty
    a_oe: assert property (p_oe) else $error("drivers on while disabled");

endmodule

// file: test/sbs_bus_master.sv
// bus master model driving the burst sram control inputs one cycle at a time
`timescale 1ns/1ps
module sbs_bus_master (
    input  wire logic                           clock,
    output logic [sbs_pkg::SBS_ADDR_W-3:0]      addr_upper,
    output logic                                addr_bit_one,
    output logic                                addr_bit_zero,
    output logic                                chip_enable_n,
    output logic                                depth_bank_enable_n,
    output logic                                depth_expansion_select,
    output logic                                processor_addr_strobe_n,
    output logic                                controller_addr_strobe_n,
    output logic                                burst_step_n,
    output logic                                burst_mode_interleave,
    output logic                                byte_write_gate_n,
    output logic                                full_word_write_n,
    output logic                                byte_sel_lane_a_n,
    output logic                                byte_sel_lane_b_n,
    output logic                                byte_sel_lane_c_n,
    output logic                                byte_sel_lane_d_n,
    output logic                                output_enable_n,
    output logic [sbs_pkg::SBS_LANE_W-1:0]      data_lane_a_in,
    output logic [sbs_pkg::SBS_LANE_W-1:0]      data_lane_b_in,
    output logic [sbs_pkg::SBS_LANE_W-1:0]      data_lane_c_in,
    output logic [sbs_pkg::SBS_LANE_W-1:0]      data_lane_d_in
);
    import sbs_pkg::*;
    initial begin
        {processor_addr_strobe_n, controller_addr_strobe_n, burst_step_n} = 3'h7;
        {chip_enable_n, depth_bank_enable_n, depth_expansion_select} = 3'h3;
        {byte_write_gate_n, full_word_write_n, output_enable_n} = 3'h7;
        {byte_sel_lane_d_n, byte_sel_lane_c_n, byte_sel_lane_b_n, byte_sel_lane_a_n} = 4'hF;
        {addr_upper, addr_bit_one, addr_bit_zero} = '0;
        {data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in} = '0;
        burst_mode_interleave = 1'b0;
    end
    // one bus cycle, launched just after an edge and held until the next one
    task automatic put(input logic [1:0] k, input logic ce_n, bank_n, dsel, step_n, gw_n,
                       bwe_n, input logic [3:0] bs, input logic [SBS_ADDR_W-1:0] a,
                       input logic [SBS_DATA_W-1:0] d, input logic oe_n, md);
        logic wr;
        wr = !gw_n || (!bwe_n && bs != 4'hF);
        @(posedge clock);
        processor_addr_strobe_n <= (k != 2'h1);
        controller_addr_strobe_n <= (k != 2'h2);
        {addr_upper, addr_bit_one, addr_bit_zero} <= a;
        {chip_enable_n, depth_bank_enable_n, depth_expansion_select} <= {ce_n, bank_n, dsel};
        {burst_step_n, burst_mode_interleave, output_enable_n} <= {step_n, md, oe_n};
        {full_word_write_n, byte_write_gate_n} <= {gw_n, bwe_n};
        {byte_sel_lane_d_n, byte_sel_lane_c_n, byte_sel_lane_b_n, byte_sel_lane_a_n} <= bs;
        // data not being written is scrambled so stale values never pass for a match
        {data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in} <= wr ? d :
            ~{data_lane_d_in, data_lane_c_in, data_lane_b_in, data_lane_a_in};
    endtask
endmodule

// file: test/tb.sv
// self-checking bench for the burst sram control block
`timescale 1ns/1ps
module tb;
    import sbs_pkg::*;
    localparam logic hi = 1'b1;
    localparam logic lo = 1'b0;
    logic                  clock = 1'b0;
    logic                  reset_n = 1'b0;
    logic [SBS_ADDR_W-3:0] addr_upper, base, blk;
    logic                  addr_bit_one, addr_bit_zero, chip_enable_n, depth_bank_enable_n;
    logic                  depth_expansion_select, processor_addr_strobe_n, burst_step_n;
    logic                  controller_addr_strobe_n, burst_mode_interleave, byte_write_gate_n;
    logic                  full_word_write_n, output_enable_n, data_oe_n, write_buf_ready;
    logic                  byte_sel_lane_a_n, byte_sel_lane_b_n, byte_sel_lane_c_n;
    logic                  byte_sel_lane_d_n, mode_v = 1'b0, act = 1'b0, rd = 1'b0;
    logic                  exp_drv = 1'b0, exp_known = 1'b0;
    logic [SBS_LANE_W-1:0] data_lane_a_in, data_lane_b_in, data_lane_c_in, data_lane_d_in;
    logic [SBS_LANE_W-1:0] data_lane_a_out, data_lane_b_out, data_lane_c_out, data_lane_d_out;
    logic [SBS_DATA_W-1:0] exp_q, mem [int];
    logic [1:0]            st, cnt;
    int                    failures = 0, checks_done = 0, cycles = 0;

    sbs_sram_ctrl dut (.*);
    sbs_bus_master m (.*);

    always #4 clock = ~clock;

    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end

    task automatic cmp_bit(input string what, input logic exp, got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0b seen %0b", what, exp, got);
        end
    endtask

    task automatic cmp_word(input logic [SBS_DATA_W-1:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH read_data expected %h seen %h", exp, got);
        end
    endtask

    // drive one cycle, check the previous one, then advance the reference model
    task automatic go(input logic [1:0] k, input logic ce_n, bank_n, dsel, step_n, gw_n,
                      bwe_n, input logic [3:0] bs, input logic [SBS_ADDR_W-1:0] a,
                      input logic [SBS_DATA_W-1:0] d);
        logic                  wr;
        logic [3:0]            mk;
        logic [SBS_ADDR_W-1:0] cur;
        m.put(k, ce_n, bank_n, dsel, step_n, gw_n, bwe_n, bs, a, d, 1'($urandom), mode_v);
        #1;
        cmp_bit("data_oe_n", !(exp_drv && !output_enable_n), data_oe_n);
        if (exp_drv && exp_known)
            cmp_word(exp_q, {data_lane_d_out, data_lane_c_out, data_lane_b_out,
                             data_lane_a_out});
        wr = !gw_n || (!bwe_n && bs != 4'hF);
        mk = !gw_n ? 4'hF : (!bwe_n ? ~bs : 4'h0);
        if ((k == 2'h1 && !ce_n) || k == 2'h2) begin
            act = !ce_n && !bank_n && dsel;
            {base, st} = a;
            cnt = 2'h0;
            rd = (k == 2'h1) || !wr;
        end else if (act) begin
            cnt = cnt + {1'b0, !step_n};
            rd = !wr;
        end
        cur = {base, mode_v ? st ^ cnt : 2'(st + cnt)};
        exp_drv = act && rd;
        if (act && !rd)
            for (int i = 0; i < 4; i++)
                if (mk[i])
                    mem[int'(cur)][i*9 +: 9] = d[i*9 +: 9];
        exp_known = mem.exists(int'(cur));
        exp_q = exp_known ? mem[int'(cur)] : '0;
    endtask

    task automatic idle(input int n);
        repeat (n) go(2'h0, hi, hi, hi, hi, hi, hi, 4'hF, '0, '0);
    endtask

    task automatic desel();
        go(2'h2, hi, lo, hi, hi, hi, hi, 4'hF, '0, '0);
    endtask

    task automatic note(input string s);
        $display("test %s done", s);
    endtask

    initial begin
        void'($urandom(32'hFD46));
        blk = 15'($urandom);
        repeat (3) @(posedge clock);
        reset_n <= hi;
        #1;
        cmp_bit("data_oe_n", hi, data_oe_n);
        cmp_bit("write_buf_ready", hi, write_buf_ready);
        for (int i = 0; i < 4; i++)
            go(2'h2, lo, lo, hi, hi, lo, hi, 4'($urandom), {blk, 2'(i)},
               36'({$urandom, $urandom}));
        desel();
        idle(3);
        note("full_word_write");
        for (int i = 0; i < 4; i++)
            go(2'h2, lo, lo, hi, hi, hi, lo, ~(4'h1 << i), {blk, 2'(i)},
               36'({$urandom, $urandom}));
        desel();
        idle(3);
        go(2'h1, lo, lo, hi, hi, lo, hi, 4'h0, {blk, 2'h0}, '0);
        go(2'h0, hi, hi, hi, hi, lo, hi, 4'hF, '0, 36'({$urandom, $urandom}));
        desel();
        idle(3);
        note("byte_write");
        for (int md = 0; md < 2; md++) begin
            mode_v = md[0];
            for (int s = 0; s < 4; s++) begin
                if (s[0])
                    go(2'h2, lo, lo, hi, hi, hi, hi, 4'h0, {blk, 2'(s)}, '0);
                else
                    go(2'h1, lo, lo, hi, hi, hi, hi, 4'hF, {blk, 2'(s)}, '0);
                // two steps before the wait so the two-step count check is reached
                for (int j = 0; j < 5; j++)
                    go(2'h0, hi, hi, hi, 1'(j == 2), hi, hi, 4'($urandom), '0,
                       '0);
            end
        end
        note("burst");
        go(2'h1, lo, lo, hi, hi, hi, hi, 4'hF, {blk, 2'h1}, '0);
        go(2'h1, hi, lo, hi, hi, hi, hi, 4'hF, {blk, 2'h3}, '0);
        go(2'h1, lo, hi, hi, lo, hi, hi, 4'hF, {blk, 2'h1}, '0);
        idle(2);
        go(2'h1, lo, lo, hi, hi, hi, hi, 4'hF, {blk, 2'h2}, '0);
        go(2'h2, lo, lo, lo, hi, hi, hi, 4'hF, {blk, 2'h2}, '0);
        go(2'h1, hi, lo, hi, lo, hi, hi, 4'hF, {blk, 2'h2}, '0);
        idle(2);
        cmp_bit("write_buf_ready", hi, write_buf_ready);
        note("deselect");
        conclude();
    end
endmodule
